// ==== dv/tb.sv ====
// Self-checking bench of the supervisory timers and detectors
`timescale 1ns/10ps
module tb;
	localparam int B_DONE = 6;
	localparam int B_ARR = 3;
	localparam int B_RUN = 1;
	localparam int B_SLEEP = 0;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic run_cmd = 1'b0;
	logic [15:0] set_freq = 16'h0000;
	logic [15:0] out_current = 16'h0000;
	logic [15:0] analog_voltage_input = 16'h01F4;
	logic [7:0] heatsink_temp = 8'h14;
	dst_pkg::dst_cfg_type cfg;
	dst_pkg::dst_status_type status;
	logic [15:0] remaining_time;
	int num_errors = 0;
	int compares = 0;
	int n;

	always #12.5 sys_clk = ~sys_clk;

	// Two clocks a base tick keeps 0.1 min at 120 clocks
	dst_supervisor #(.TICK_CYCLES(2)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .run_cmd(run_cmd),
		.set_freq(set_freq), .out_current(out_current), .analog_voltage_input(analog_voltage_input),
		.heatsink_temp(heatsink_temp), .cfg(cfg), .status(status), .remaining_time(remaining_time));

	task automatic complete_run();
		if (num_errors == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] act, input logic [15:0] exp);
		compares++;
		if (act !== exp) begin
			num_errors++;
			$display("ERROR t=%0t act=%h exp=%h", $time, act, exp);
		end
	endtask

	task automatic chk_bit(input logic act, input logic exp);
		chk({15'h0000, act}, {15'h0000, exp});
	endtask

	// Free-running base tick makes elapsed times fuzzy by a tick, so a window is judged
	task automatic chk_rng(input int act, input int lo, input int hi);
		compares++;
		if (act < lo || act > hi) begin
			num_errors++;
			$display("ERROR t=%0t act=%h exp=%h..%h", $time, act, lo, hi);
		end
	endtask

	task automatic step(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask

	task automatic wait_bit(input int idx, input logic val, input int lim);
		logic [8:0] s;
		n = 0;
		#1;
		s = status;
		while (s[idx] !== val) begin
			step(1);
			n++;
			s = status;
			if (n > lim) begin
				num_errors++;
				$display("ERROR t=%0t act=%h exp=%h", $time, s[idx], val);
				complete_run();
			end
		end
	endtask

	task automatic t_window();
		logic [15:0] cur [6] = '{16'h01EA, 16'h01FE, 16'h01FF, 16'h01E9, 16'h03E8, 16'h03E9};
		logic [1:0] exp [6] = '{2'h1, 2'h1, 2'h0, 2'h0, 2'h2, 2'h0};
		for (int i = 0; i < 6; i++) begin
			@(posedge sys_clk);
			out_current <= cur[i];
			step(2);
			chk({14'h0000, status.cur_arrive}, {14'h0000, exp[i]});
		end
	endtask

	task automatic t_ain();
		logic [15:0] v [6] = '{16'h0136, 16'h0135, 16'h02A8, 16'h02A9, 16'h044C, 16'h044D};
		logic exp [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
		for (int i = 0; i < 6; i++) begin
			@(posedge sys_clk);
			analog_voltage_input <= v[i];
			// Upper limit above its ceiling must act as 11.00 V
			if (i == 4) begin
				cfg.ain_hi <= 16'h04B0;
			end
			step(2);
			chk_bit(status.ain_out_range, exp[i]);
		end
		@(posedge sys_clk);
		cfg.ain_hi <= dst_pkg::AIN_HI_RST;
		analog_voltage_input <= 16'h01F4;
	endtask

	task automatic t_temp();
		logic [10:0] tv [5] = '{{8'h4B, 3'b011}, {8'h4A, 3'b001}, {8'h29, 3'b001},
			{8'h28, 3'b000}, {8'h28, 3'b101}};
		for (int i = 0; i < 5; i++) begin
			@(posedge sys_clk);
			heatsink_temp <= tv[i][10:3];
			cfg.fan_mode <= tv[i][2];
			step(2);
			chk({14'h0000, status.temp_reached, status.fan_on}, {14'h0000, tv[i][1:0]});
		end
		@(posedge sys_clk);
		cfg.fan_mode <= dst_pkg::FAN_WITH_RUN;
		heatsink_temp <= 8'h14;
	endtask

	// Every source code must yield a 0.2 min run
	task automatic t_timed();
		logic [15:0] pre [4] = '{16'h0002, 16'h0004, 16'h0002, 16'h0002};
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			cfg.timer_en <= 1'b1;
			cfg.timer_src <= 2'(i);
			cfg.timer_preset <= pre[i];
			run_cmd <= 1'b1;
			step(3);
			chk(remaining_time, 16'h0002);
			chk_bit(status.fan_on, 1'b1);
			wait_bit(B_DONE, 1'b1, 400);
			chk_rng(n, 228, 245);
			chk_bit(status.drive_run, 1'b0);
			chk(remaining_time, 16'h0000);
			step(5);
			chk_bit(status.drive_run, 1'b0);
			@(posedge sys_clk);
			run_cmd <= 1'b0;
			step(3);
		end
		@(posedge sys_clk);
		cfg.timer_en <= 1'b0;
	endtask

	task automatic t_arrive();
		@(posedge sys_clk);
		cfg.arrive_time <= 16'h0001;
		run_cmd <= 1'b1;
		wait_bit(B_ARR, 1'b1, 200);
		chk_rng(n, 115, 125);
		chk_bit(status.drive_run, 1'b1);
		@(posedge sys_clk);
		run_cmd <= 1'b0;
		step(2);
		chk_bit(status.run_arrive, 1'b0);
	endtask

	task automatic t_sleep();
		@(posedge sys_clk);
		cfg.sleep_freq <= 16'h0064;
		cfg.wake_freq <= 16'h00C8;
		cfg.sleep_dly <= 16'h0003;
		cfg.wake_dly <= 16'h0003;
		// Set frequency comes straight from the bench, so no regulator runs here
		set_freq <= 16'h012C;
		run_cmd <= 1'b1;
		step(3);
		chk_bit(status.drive_run, 1'b1);
		@(posedge sys_clk);
		set_freq <= 16'h0064;
		wait_bit(B_SLEEP, 1'b1, 20);
		chk_rng(n, 5, 10);
		chk_bit(status.drive_run, 1'b0);
		@(posedge sys_clk);
		set_freq <= 16'h00C7;
		step(20);
		chk_bit(status.sleeping, 1'b1);
		@(posedge sys_clk);
		set_freq <= 16'h00C8;
		wait_bit(B_RUN, 1'b1, 20);
		chk_rng(n, 5, 10);
		chk_bit(status.sleeping, 1'b0);
		@(posedge sys_clk);
		cfg.sleep_freq <= 16'h0000;
		cfg.wake_freq <= 16'h0000;
		set_freq <= 16'h0000;
		step(30);
		chk({14'h0000, status.drive_run, status.sleeping}, 16'h0002);
		@(posedge sys_clk);
		run_cmd <= 1'b0;
	endtask

	initial begin
		cfg = '0;
		cfg.cur_set[0] = 16'h01F4;
		cfg.cur_width[0] = 16'h000A;
		cfg.cur_set[1] = 16'h03E8;
		cfg.ain_lo = dst_pkg::AIN_LO_RST;
		cfg.ain_hi = dst_pkg::AIN_HI_RST;
		cfg.temp_thresh = dst_pkg::TEMP_THR_RST;
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		step(1);
		chk({7'h00, status}, 16'h0000);
		chk(remaining_time, 16'h0000);
		t_window();
		t_ain();
		t_temp();
		t_timed();
		t_arrive();
		t_sleep();
		complete_run();
	end
endmodule

// ==== logic/dst_pkg.sv ====
// Shared constants and types of the drive supervisory timers and detectors
package dst_pkg;

	// Time base
	localparam int CLK_PERIOD_NS = 25;
	localparam int TICK_PERIOD_NS = 100_000_000;
	localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int TICKS_PER_TENTH_MIN = 60;
	localparam logic [5:0] TENTH_MIN_LAST = 6'h3B;

	// Ranges, units of 0.1 min or 0.1 s
	localparam logic [15:0] TIME_MAX = 16'hFDE8;

	// Analog input, units of 0.01 V
	localparam logic [15:0] AIN_LO_RST = 16'h0136;
	localparam logic [15:0] AIN_HI_RST = 16'h02A8;
	localparam logic [15:0] AIN_HI_MAX = 16'h044C;
	localparam logic [15:0] AIN_FULL = 16'h03E8;

	// Heatsink, degrees Celsius
	localparam logic [7:0] TEMP_THR_RST = 8'h4B;
	localparam logic [7:0] TEMP_THR_MAX = 8'h64;
	localparam logic [7:0] FAN_STOP_TEMP = 8'h28;

	// Run-time source codes
	localparam logic [1:0] SRC_PRESET = 2'h0;
	localparam logic [1:0] SRC_AIN = 2'h1;

	// Fan modes
	localparam logic FAN_WITH_RUN = 1'b0;
	localparam logic FAN_ALWAYS = 1'b1;

	typedef enum logic [1:0] {
		ST_STOP = 2'b00,
		ST_RUN = 2'b01,
		ST_SLEEP = 2'b10,
		ST_DONE = 2'b11
	} dst_state_type;

	typedef struct packed {
		logic [1:0][15:0] cur_set;
		logic [1:0][15:0] cur_width;
		logic timer_en;
		logic [1:0] timer_src;
		logic [15:0] timer_preset;
		logic [15:0] ain_lo;
		logic [15:0] ain_hi;
		logic [7:0] temp_thresh;
		logic fan_mode;
		logic [15:0] wake_freq;
		logic [15:0] wake_dly;
		logic [15:0] sleep_freq;
		logic [15:0] sleep_dly;
		logic [15:0] arrive_time;
	} dst_cfg_type;

	typedef struct packed {
		logic [1:0] cur_arrive;
		logic timed_done;
		logic ain_out_range;
		logic temp_reached;
		logic run_arrive;
		logic fan_on;
		logic drive_run;
		logic sleeping;
	} dst_status_type;

endpackage

// ==== logic/dst_supervisor.sv ====
// Drive supervisory timers, window detectors, fan and sleep control
// Operation
// - Current within either window asserts arrival
// - Timed run stops drive, flags completion
// - Run timer restarts each start; remaining readable
// - Source 0 preset, 1 analog scaled
// - Preset in 0.1 min, up to 6500.0
// - Analog outside limits flags out-of-range
// - Limits 3.10/6.80 V default, bounded
// - Heatsink at threshold flags temperature reached
// - Mode 0: fan on running or hot
// - Mode 1: fan always on
// - Low set frequency for delay enters sleep
// - Asleep, commanded, high frequency: wake after delay
// - Both frequencies zero disable sleep and wake
// - Elapsed run time reaching setting flags arrival
`timescale 1ns/10ps
module dst_supervisor #(
	parameter int TICK_CYCLES = dst_pkg::TICK_CYCLES_DEF
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic run_cmd,
	input wire logic [15:0] set_freq,
	input wire logic [15:0] out_current,
	input wire logic [15:0] analog_voltage_input,
	input wire logic [7:0] heatsink_temp,
	input wire dst_pkg::dst_cfg_type cfg,
	output dst_pkg::dst_status_type status,
	output logic [15:0] remaining_time
);

	// Time base: 0.1 s tick and 0.1 min tick
	logic [31:0] tick_cnt_ff;
	logic [31:0] nxt_tick_cnt;
	logic [5:0] min_cnt_ff;
	logic [5:0] nxt_min_cnt;
	wire base_tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1));
	wire min_tick = base_tick && (min_cnt_ff == dst_pkg::TENTH_MIN_LAST);

	dst_pkg::dst_state_type state_ff;
	dst_pkg::dst_state_type nxt_state;
	wire running = (state_ff == dst_pkg::ST_RUN);

	// Base divider runs free, so the first tenth-minute may come up to 0.1 s early
	assign nxt_tick_cnt = base_tick ? 32'h0 : tick_cnt_ff + 32'h1;
	assign nxt_min_cnt = !running ? 6'h0 : !base_tick ? min_cnt_ff
		: (min_cnt_ff == dst_pkg::TENTH_MIN_LAST) ? 6'h0 : min_cnt_ff + 6'h1;

	// Preset clamp and run-time source
	wire [15:0] preset_sat = (cfg.timer_preset > dst_pkg::TIME_MAX) ? dst_pkg::TIME_MAX
		: cfg.timer_preset;
	wire [15:0] ain_sat = (analog_voltage_input > dst_pkg::AIN_FULL) ? dst_pkg::AIN_FULL
		: analog_voltage_input;
	// Product kept 32 bits wide so full preset times full scale cannot wrap
	wire [31:0] ain_prod = {16'h0, ain_sat} * {16'h0, preset_sat};
	wire [31:0] ain_scaled = ain_prod / {16'h0, dst_pkg::AIN_FULL};
	// Reserved codes fall back to the preset
	wire [15:0] nxt_run_limit = (cfg.timer_src == dst_pkg::SRC_AIN) ? ain_scaled[15:0]
		: preset_sat;
	logic [15:0] run_limit_ff;

	wire [15:0] arrive_sat = (cfg.arrive_time > dst_pkg::TIME_MAX) ? dst_pkg::TIME_MAX
		: cfg.arrive_time;
	wire [15:0] sleep_dly_sat = (cfg.sleep_dly > dst_pkg::TIME_MAX) ? dst_pkg::TIME_MAX
		: cfg.sleep_dly;
	wire [15:0] wake_dly_sat = (cfg.wake_dly > dst_pkg::TIME_MAX) ? dst_pkg::TIME_MAX
		: cfg.wake_dly;

	// Timers
	logic [15:0] tr_count;
	logic tr_done;
	logic arr_done;
	logic slp_done;
	logic wk_done;

	wire tr_en = running && cfg.timer_en;
	wire sleep_en = (cfg.wake_freq != 16'h0) || (cfg.sleep_freq != 16'h0);
	wire slp_en = running && sleep_en && run_cmd && (set_freq <= cfg.sleep_freq);
	wire wk_en = (state_ff == dst_pkg::ST_SLEEP) && sleep_en && run_cmd
		&& (set_freq >= cfg.wake_freq);

	dst_tick_timer #(.WIDTH(16)) u_run_timer (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.en(tr_en),
		.tick(min_tick),
		.limit(run_limit_ff),
		.count(tr_count),
		.done(tr_done)
	);

	dst_tick_timer #(.WIDTH(16)) u_arrive_timer (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.en(running),
		.tick(min_tick),
		.limit(arrive_sat),
		.count(),
		.done(arr_done)
	);

	dst_tick_timer #(.WIDTH(16)) u_sleep_timer (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.en(slp_en),
		.tick(base_tick),
		.limit(sleep_dly_sat),
		.count(),
		.done(slp_done)
	);

	dst_tick_timer #(.WIDTH(16)) u_wake_timer (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.en(wk_en),
		.tick(base_tick),
		.limit(wake_dly_sat),
		.count(),
		.done(wk_done)
	);

	// Run and stop sequencing; expiry outranks sleep
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			dst_pkg::ST_STOP: begin
				if (run_cmd) begin
					nxt_state = dst_pkg::ST_RUN;
				end
			end
			dst_pkg::ST_RUN: begin
				if (!run_cmd) begin
					nxt_state = dst_pkg::ST_STOP;
				end else if (tr_done) begin
					nxt_state = dst_pkg::ST_DONE;
				end else if (slp_done) begin
					nxt_state = dst_pkg::ST_SLEEP;
				end
			end
			dst_pkg::ST_SLEEP: begin
				if (!run_cmd || !sleep_en) begin
					nxt_state = dst_pkg::ST_STOP;
				end else if (wk_done) begin
					nxt_state = dst_pkg::ST_RUN;
				end
			end
			dst_pkg::ST_DONE: begin
				// A fresh command is needed after timed completion
				if (!run_cmd) begin
					nxt_state = dst_pkg::ST_STOP;
				end
			end
		endcase
	end

	// Current arrival windows
	// Absolute difference avoids a wrap when the setpoint lies above the current
	logic [1:0] cur_within;
	generate
		for (genvar i = 0; i < 2; i++) begin : g_cur
			wire [15:0] cur_diff = (out_current >= cfg.cur_set[i])
				? out_current - cfg.cur_set[i] : cfg.cur_set[i] - out_current;
			assign cur_within[i] = (cur_diff <= cfg.cur_width[i]);
		end
	endgenerate

	// Analog protection limits
	wire [15:0] ain_hi_eff = (cfg.ain_hi > dst_pkg::AIN_HI_MAX) ? dst_pkg::AIN_HI_MAX
		: cfg.ain_hi;
	wire [15:0] ain_lo_eff = (cfg.ain_lo > ain_hi_eff) ? ain_hi_eff : cfg.ain_lo;
	wire ain_out = (analog_voltage_input > ain_hi_eff)
		|| (analog_voltage_input < ain_lo_eff);

	// Heatsink and fan
	wire [7:0] temp_thr_eff = (cfg.temp_thresh > dst_pkg::TEMP_THR_MAX)
		? dst_pkg::TEMP_THR_MAX : cfg.temp_thresh;
	wire temp_hit = (heatsink_temp >= temp_thr_eff);
	// Next state is used so the fan starts in the same cycle as the drive
	wire nxt_run = (nxt_state == dst_pkg::ST_RUN);
	wire fan_req = (cfg.fan_mode == dst_pkg::FAN_ALWAYS)
		|| nxt_run || (heatsink_temp > dst_pkg::FAN_STOP_TEMP);

	// One register for all flags keeps them aligned to the same edge
	dst_pkg::dst_status_type status_ff;
	dst_pkg::dst_status_type nxt_status;
	logic [15:0] remain_ff;
	// Clamped at zero, since a lowered preset may fall below the count
	wire [15:0] nxt_remain = (tr_count >= run_limit_ff) ? 16'h0
		: run_limit_ff - tr_count;

	assign nxt_status.cur_arrive = cur_within;
	assign nxt_status.timed_done = (nxt_state == dst_pkg::ST_DONE);
	assign nxt_status.ain_out_range = ain_out;
	assign nxt_status.temp_reached = temp_hit;
	assign nxt_status.run_arrive = arr_done && nxt_run;
	assign nxt_status.fan_on = fan_req;
	assign nxt_status.drive_run = nxt_run;
	assign nxt_status.sleeping = (nxt_state == dst_pkg::ST_SLEEP);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			tick_cnt_ff <= 32'h0;
			min_cnt_ff <= 6'h0;
			state_ff <= dst_pkg::ST_STOP;
			run_limit_ff <= 16'h0;
			remain_ff <= 16'h0;
			status_ff <= '0;
		end else begin
			tick_cnt_ff <= nxt_tick_cnt;
			min_cnt_ff <= nxt_min_cnt;
			state_ff <= nxt_state;
			run_limit_ff <= nxt_run_limit;
			remain_ff <= nxt_remain;
			status_ff <= nxt_status;
		end
	end

	assign status = status_ff;
	assign remaining_time = remain_ff;

	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_cur_window0: assert property (cur_within[0] |=> status.cur_arrive[0])
		else $error("current window 0 not flagged");
	a_cur_window1: assert property (!cur_within[1] |=> !status.cur_arrive[1])
		else $error("current window 1 flagged outside");
	a_timed_stop: assert property (running && run_cmd && tr_done |=>
		state_ff == dst_pkg::ST_DONE && status.timed_done && !status.drive_run)
		else $error("timed run did not stop");
	a_done_hold: assert property (state_ff == dst_pkg::ST_DONE && run_cmd |=>
		state_ff == dst_pkg::ST_DONE && !status.drive_run)
		else $error("restart without a fresh command");
	a_done_remain: assert property (state_ff == dst_pkg::ST_DONE
		&& $past(state_ff) == dst_pkg::ST_RUN |-> remaining_time == 16'h0)
		else $error("remaining time not zero at expiry");
	a_timer_restart: assert property (running && !$past(running) |-> tr_count == 16'h0)
		else $error("run timer not restarted");
	a_remain_value: assert property (running ##1 running |->
		remaining_time == (($past(tr_count) >= $past(run_limit_ff)) ? 16'h0
		: $past(run_limit_ff) - $past(tr_count)))
		else $error("remaining time wrong");
	a_src_preset: assert property (cfg.timer_src != dst_pkg::SRC_AIN |=>
		run_limit_ff == $past(preset_sat))
		else $error("preset source not used");
	a_src_scaled: assert property (cfg.timer_src == dst_pkg::SRC_AIN
		&& analog_voltage_input >= dst_pkg::AIN_FULL |=> run_limit_ff == $past(preset_sat))
		else $error("analog full scale not equal to preset");
	a_preset_max: assert property (run_limit_ff <= dst_pkg::TIME_MAX)
		else $error("run limit above range");
	a_ain_high: assert property (analog_voltage_input > ain_hi_eff
		|=> status.ain_out_range)
		else $error("analog high not flagged");
	a_ain_low: assert property (analog_voltage_input < ain_lo_eff
		|=> status.ain_out_range)
		else $error("analog low not flagged");
	a_ain_inside: assert property (analog_voltage_input <= ain_hi_eff
		&& analog_voltage_input >= ain_lo_eff |=> !status.ain_out_range)
		else $error("analog flagged inside limits");
	a_ain_bounds: assert property (ain_lo_eff <= ain_hi_eff
		&& ain_hi_eff <= dst_pkg::AIN_HI_MAX)
		else $error("analog limits unbounded");
	a_temp_reach: assert property (heatsink_temp >= temp_thr_eff |=> status.temp_reached)
		else $error("temperature not flagged");
	a_temp_below: assert property (heatsink_temp < temp_thr_eff
		|=> !status.temp_reached)
		else $error("temperature flagged early");
	a_fan_run: assert property (status.drive_run |-> status.fan_on)
		else $error("fan off while running");
	a_fan_always: assert property (cfg.fan_mode == dst_pkg::FAN_ALWAYS |=> status.fan_on)
		else $error("fan off in mode 1");
	a_fan_cold: assert property (cfg.fan_mode == dst_pkg::FAN_WITH_RUN && !nxt_run
		&& heatsink_temp <= dst_pkg::FAN_STOP_TEMP |=> !status.fan_on)
		else $error("fan on while stopped and cool");
	a_sleep_enter: assert property (running && run_cmd && slp_done && !tr_done |=>
		status.sleeping)
		else $error("sleep not entered");
	a_sleep_block: assert property (running && run_cmd && !tr_done
		&& set_freq > cfg.sleep_freq |=> running)
		else $error("left run above sleep frequency");
	a_wake_start: assert property (state_ff == dst_pkg::ST_SLEEP && run_cmd && wk_done |=>
		running && status.drive_run)
		else $error("wake did not restart");
	a_no_wake: assert property (state_ff == dst_pkg::ST_SLEEP
		&& set_freq < cfg.wake_freq |=> !running)
		else $error("woke below wake frequency");
	a_sleep_off: assert property (!sleep_en |=> state_ff != dst_pkg::ST_SLEEP)
		else $error("sleep while disabled");
	a_run_arrive: assert property (status.run_arrive |-> status.drive_run)
		else $error("arrival flagged while stopped");
	a_arrive_zero: assert property (running && cfg.arrive_time == 16'h0 && nxt_run
		|=> status.run_arrive)
		else $error("zero arrival time not flagged");
	a_tick_clear: assert property (!running |=> tr_count == 16'h0 && min_cnt_ff == 6'h0)
		else $error("counters not cleared");

	// Main scenarios to be reached
	c_sleep: cover property (running ##1 state_ff == dst_pkg::ST_SLEEP);
	c_wake: cover property (state_ff == dst_pkg::ST_SLEEP ##1 running);
	c_timed: cover property (running ##1 state_ff == dst_pkg::ST_DONE);
	c_ain: cover property (status.ain_out_range ##1 !status.ain_out_range);
	c_temp: cover property (status.temp_reached && status.fan_on);

endmodule

// ==== logic/dst_tick_timer.sv ====
// Saturating tick counter with a reach flag
`timescale 1ns/10ps
module dst_tick_timer #(
	parameter int WIDTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic tick,
	input wire logic [WIDTH-1:0] limit,
	output logic [WIDTH-1:0] count,
	output logic done
);

	logic [WIDTH-1:0] count_ff;
	logic [WIDTH-1:0] nxt_count;
	wire at_limit = (count_ff >= limit);

	// Clears whenever the qualifying condition drops
	assign nxt_count = !en ? '0 : (tick && !at_limit) ? count_ff + 1'b1 : count_ff;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			count_ff <= '0;
		end else begin
			count_ff <= nxt_count;
		end
	end

	assign count = count_ff;
	assign done = en && at_limit;

endmodule
